// File: rtl/sbl_cfg.svh
// register map, field positions, reset values and timing counts of the break/low-power block
`ifndef SBL_CFG_SVH
`define SBL_CFG_SVH
// ==========================================================================
// register byte addresses
`define SBL_ADDR_BRK_STAT   16'hFE00
`define SBL_ADDR_RST_SRC    16'hFE01
`define SBL_ADDR_BRK_CTRL   16'hFE03
`define SBL_ADDR_IRQ_STAT   16'hFE04
`define SBL_ADDR_IRQ_MASK   16'hFE05
// ==========================================================================
// field positions
`define SBL_BIT_WAIT_BRK    1
`define SBL_BIT_CLR_EN      7
`define SBL_BIT_POWER_ON    7
`define SBL_BIT_PIN         6
`define SBL_BIT_WDOG        5
`define SBL_BIT_BAD_OP      4
`define SBL_BIT_BAD_FETCH   3
`define SBL_BIT_MONITOR     2
`define SBL_BIT_LOW_VOLT    1
`define SBL_EVT_WAIT_BRK    0
`define SBL_EVT_STOP_DONE   1
// ==========================================================================
// reset values and constants
`define SBL_RST_SRC_INIT    8'h80
`define SBL_ZERO8           8'h00
`define SBL_IRQ_W           2
`define SBL_ERASED          8'hFF
// ==========================================================================
// stop recovery times in quad bus clock cycles
`define SBL_RECOV_LONG      4096
`define SBL_RECOV_SHORT     32
`define SBL_CNT_W           13
`endif

// File: rtl/sbl_pkg.sv
// types shared by the break/low-power block
`default_nettype none
package sbl_pkg;
  // ==========================================================================
  // power state, one-hot
  typedef enum logic [3:0] {
    SBL_RUN   = 4'h1,
    SBL_WAIT  = 4'h2,
    SBL_STOP  = 4'h4,
    SBL_RECOV = 4'h8
  } sbl_state_t;
endpackage
`default_nettype wire

// File: rtl/sbl_top.sv
// break flag protection, wait/stop control and status registers
// Summary of operation
// - in break, peripheral flag clears granted only while clear enable is set
// - a flag cleared in break stays cleared; no restore after break
// - second step of a two-step clear is gated only while in break
// - wait or stop instruction pulses the interrupt mask clear
// - wait stops processor clock, peripheral clock keeps running
// - interrupt in wait wakes processor, stacking one cycle later
// - reset or break also exits wait; break sets wait-exit-by-break bit
// - watchdog enabled and running in wait while disable option is zero
// - stop clears counter, gates both bus clocks; interrupt, break or reset exits
// - stop exit stacking starts only after recovery time elapsed
// - recovery is 4096 cycles, or 32 with short recovery option
// - counter held cleared during stop, then times the recovery
// - registers decoded at FE00, FE01, FE03, FE04 and FE05
// - wait-exit-by-break reads one after break exit; write zero or reset clears
// - reading the reset source register clears all its flags
// - power-on sets power-on flag, clears all other reset flags
// - every other reset source sets its own flag
// - monitor flag set on monitor entry with pin high and vectors erased
// - break request in run, wait, or stop without an interrupt forces software interrupt vector fetch
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "sbl_cfg.svh"
module sbl_top
  import sbl_pkg::*;
#(
  parameter int NFLAG       = 8,
  parameter int RECOV_LONG  = `SBL_RECOV_LONG,
  parameter int RECOV_SHORT = `SBL_RECOV_SHORT
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [15:0]      reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             cpu_wait_exec,
  input  wire logic             cpu_stop_exec,
  input  wire logic             module_irq,
  input  wire logic             brk_req,
  input  wire logic             brk_done,
  input  wire logic             power_on_evt,
  input  wire logic             pin_rst_evt,
  input  wire logic             wdog_rst_evt,
  input  wire logic             bad_opcode_evt,
  input  wire logic             bad_fetch_evt,
  input  wire logic             monitor_entry_evt,
  input  wire logic             irq_pin_high,
  input  wire logic [7:0]       vec_fffe,
  input  wire logic [7:0]       vec_ffff,
  input  wire logic             low_voltage_evt,
  input  wire logic             short_recovery_opt,
  input  wire logic             watchdog_disable_opt,
  input  wire logic [NFLAG-1:0] flag_clr_req,
  output logic      [NFLAG-1:0] flag_clr_gnt,
  output logic                  in_break,
  output logic                  force_swi_vec,
  output logic                  imask_clear,
  output logic                  stack_start,
  output logic                  cpu_clk_en,
  output logic                  bus_clock_double_en,
  output logic                  bus_clock_quad_en,
  output logic                  recov_cnt_rst,
  output logic                  watchdog_en,
  output logic                  irq
);
  localparam logic [`SBL_CNT_W-1:0] LIM_LONG  = `SBL_CNT_W'(RECOV_LONG - 1);
  localparam logic [`SBL_CNT_W-1:0] LIM_SHORT = `SBL_CNT_W'(RECOV_SHORT - 1);

  // ==========================================================================
  // elaboration checks
  generate
    if (NFLAG < 1 || RECOV_SHORT < 1 || RECOV_SHORT > RECOV_LONG ||
        RECOV_LONG > (1 << `SBL_CNT_W)) begin : g_bad_param
      $error("sbl_top: parameter out of range");
    end
  endgenerate

  // ==========================================================================
  // register decode
  logic sel_brk_stat;
  logic sel_rst_src;
  logic sel_brk_ctrl;
  logic sel_irq_stat;
  logic sel_irq_mask;
  assign sel_brk_stat = (reg_addr == `SBL_ADDR_BRK_STAT);
  assign sel_rst_src  = (reg_addr == `SBL_ADDR_RST_SRC);
  assign sel_brk_ctrl = (reg_addr == `SBL_ADDR_BRK_CTRL);
  assign sel_irq_stat = (reg_addr == `SBL_ADDR_IRQ_STAT);
  assign sel_irq_mask = (reg_addr == `SBL_ADDR_IRQ_MASK);

  // ==========================================================================
  // state and storage
  sbl_state_t              state_q;
  sbl_state_t              state_d;
  logic [`SBL_CNT_W-1:0]   cnt_q;
  logic [`SBL_CNT_W-1:0]   lim_q;
  logic                    brk_pend_q;
  logic                    in_break_q;
  logic                    clr_en_q;
  logic                    wait_brk_q;
  logic [7:0]              rst_src_q;
  logic [`SBL_IRQ_W-1:0]   irq_stat_q;
  logic [`SBL_IRQ_W-1:0]   irq_mask_q;
  logic [7:0]              rdata_q;
  logic [NFLAG-1:0]        gnt_q;
  logic                    force_q;
  logic                    imask_q;
  logic                    stack_q;
  logic                    stack_pend_q;
  logic                    cpu_clk_q;
  logic                    bus_clk_q;
  logic                    cnt_rst_q;
  logic                    wdog_en_q;
  logic                    irq_q;

  // any reset source, used to leave low-power states
  logic monitor_ok;
  logic any_rst;
  logic wait_brk_exit;
  logic recov_done;
  assign monitor_ok = monitor_entry_evt & irq_pin_high &
                      (vec_fffe == `SBL_ERASED) & (vec_ffff == `SBL_ERASED);
  assign any_rst = power_on_evt | pin_rst_evt | wdog_rst_evt | bad_opcode_evt |
                   bad_fetch_evt | monitor_ok | low_voltage_evt;
  assign wait_brk_exit = (state_q == SBL_WAIT) & brk_req & ~any_rst;
  assign recov_done = (state_q == SBL_RECOV) & (cnt_q == lim_q) & ~any_rst;

  // ==========================================================================
  // power state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      SBL_RUN: begin
        if (any_rst) begin
          state_d = SBL_RUN;
        end else if (cpu_stop_exec) begin
          state_d = SBL_STOP;
        end else if (cpu_wait_exec) begin
          state_d = SBL_WAIT;
        end
      end
      SBL_WAIT: begin
        // interrupt, break or reset all wake the core
        if (any_rst || module_irq || brk_req) begin
          state_d = SBL_RUN;
        end
      end
      SBL_STOP: begin
        if (any_rst) begin
          state_d = SBL_RUN;
        end else if (module_irq || brk_req) begin
          state_d = SBL_RECOV;
        end
      end
      SBL_RECOV: begin
        if (any_rst || recov_done) begin
          state_d = SBL_RUN;
        end
      end
      default: begin
        state_d = SBL_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SBL_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // recovery counter: cleared through stop, counts during recovery
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      lim_q <= LIM_LONG;
    end else if (state_q != SBL_RECOV) begin
      cnt_q <= '0;
      // option sampled when recovery starts so a late change cannot shorten it
      lim_q <= short_recovery_opt ? LIM_SHORT : LIM_LONG;
    end else begin
      cnt_q <= cnt_q + `SBL_CNT_W'(1);
    end
  end

  // ==========================================================================
  // clock gating and watchdog enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_q <= 1'b1;
      bus_clk_q <= 1'b1;
      cnt_rst_q <= 1'b0;
      wdog_en_q <= 1'b0;
    end else begin
      cpu_clk_q <= (state_d == SBL_RUN);
      bus_clk_q <= (state_d == SBL_RUN) || (state_d == SBL_WAIT);
      cnt_rst_q <= (state_d == SBL_STOP);
      wdog_en_q <= ~watchdog_disable_opt;
    end
  end

  // ==========================================================================
  // core handshakes: mask clear, stacking, break vector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      imask_q      <= 1'b0;
      stack_q      <= 1'b0;
      stack_pend_q <= 1'b0;
      brk_pend_q   <= 1'b0;
      force_q      <= 1'b0;
    end else begin
      imask_q <= (state_q == SBL_RUN) & ~any_rst &
                 (cpu_wait_exec | cpu_stop_exec);
      // wait wake: stacking pulse lands one cycle after the wake cycle
      stack_pend_q <= (state_q == SBL_WAIT) & module_irq & ~brk_req & ~any_rst;
      stack_q <= stack_pend_q | (recov_done & ~brk_pend_q);
      // a break that ends stop without an interrupt is serviced after recovery
      if (state_q == SBL_STOP) begin
        brk_pend_q <= brk_req & ~module_irq;
      end else if (state_q != SBL_RECOV) begin
        brk_pend_q <= 1'b0;
      end
      force_q <= ((state_q == SBL_RUN) & brk_req & ~in_break_q & ~any_rst) |
                 wait_brk_exit | (recov_done & brk_pend_q);
    end
  end

  // ==========================================================================
  // break state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_break_q <= 1'b0;
    end else if (any_rst) begin
      in_break_q <= 1'b0;
    end else if (force_q) begin
      in_break_q <= 1'b1;
    end else if (brk_done) begin
      in_break_q <= 1'b0;
    end
  end

  // ==========================================================================
  // flag clear gating, one gate per peripheral flag
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          gnt_q[gi] <= 1'b0;
        end else begin
          // the peripheral keeps its own first-step state, so gating the
          // final step alone protects flags armed before break
          gnt_q[gi] <= flag_clr_req[gi] & (~in_break_q | clr_en_q);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // break flag control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clr_en_q <= 1'b0;
    end else if (reg_wr && sel_brk_ctrl) begin
      clr_en_q <= reg_wdata[`SBL_BIT_CLR_EN];
    end
  end

  // ==========================================================================
  // break status register: hardware set beats software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_brk_q <= 1'b0;
    end else if (wait_brk_exit) begin
      wait_brk_q <= 1'b1;
    end else if (any_rst) begin
      wait_brk_q <= 1'b0;
    end else if (reg_wr && sel_brk_stat && !reg_wdata[`SBL_BIT_WAIT_BRK]) begin
      wait_brk_q <= 1'b0;
    end
  end

  // ==========================================================================
  // reset source register; new events beat the read clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_src_q <= `SBL_RST_SRC_INIT;
    end else if (power_on_evt) begin
      rst_src_q <= `SBL_RST_SRC_INIT;
    end else begin
      rst_src_q <= (reg_rd && sel_rst_src) ? `SBL_ZERO8 : rst_src_q;
      if (pin_rst_evt) begin
        rst_src_q[`SBL_BIT_PIN] <= 1'b1;
      end
      if (wdog_rst_evt) begin
        rst_src_q[`SBL_BIT_WDOG] <= 1'b1;
      end
      if (bad_opcode_evt) begin
        rst_src_q[`SBL_BIT_BAD_OP] <= 1'b1;
      end
      if (bad_fetch_evt) begin
        rst_src_q[`SBL_BIT_BAD_FETCH] <= 1'b1;
      end
      if (monitor_ok) begin
        rst_src_q[`SBL_BIT_MONITOR] <= 1'b1;
      end
      if (low_voltage_evt) begin
        rst_src_q[`SBL_BIT_LOW_VOLT] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // interrupt status (write one to clear) and mask
  logic [`SBL_IRQ_W-1:0] irq_set;
  always_comb begin
    irq_set = '0;
    irq_set[`SBL_EVT_WAIT_BRK]  = wait_brk_exit;
    irq_set[`SBL_EVT_STOP_DONE] = recov_done;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      if (reg_wr && sel_irq_stat) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata[`SBL_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (reg_wr && sel_irq_mask) begin
        irq_mask_q <= reg_wdata[`SBL_IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q); // one cycle behind the status bit
    end
  end

  // ==========================================================================
  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `SBL_ZERO8;
    end else if (!reg_rd) begin
      rdata_q <= `SBL_ZERO8;
    end else if (sel_brk_stat) begin
      rdata_q <= 8'(wait_brk_q) << `SBL_BIT_WAIT_BRK;
    end else if (sel_rst_src) begin
      rdata_q <= rst_src_q;
    end else if (sel_brk_ctrl) begin
      rdata_q <= 8'(clr_en_q) << `SBL_BIT_CLR_EN;
    end else if (sel_irq_stat) begin
      rdata_q <= 8'(irq_stat_q);
    end else if (sel_irq_mask) begin
      rdata_q <= 8'(irq_mask_q);
    end else begin
      rdata_q <= `SBL_ZERO8; // unmapped reads as zero
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata           = rdata_q;
  assign flag_clr_gnt        = gnt_q;
  assign in_break            = in_break_q;
  assign force_swi_vec       = force_q;
  assign imask_clear         = imask_q;
  assign stack_start         = stack_q;
  assign cpu_clk_en          = cpu_clk_q;
  assign bus_clock_double_en = bus_clk_q;
  assign bus_clock_quad_en   = bus_clk_q;
  assign recov_cnt_rst       = cnt_rst_q;
  assign watchdog_en         = wdog_en_q;
  assign irq                 = irq_q;
endmodule
`default_nettype wire

// File: test/sbl_top_asserts.sv
// port-level checks of the break/low-power block
`timescale 1ns/1ns
`default_nettype none
`include "sbl_cfg.svh"
module sbl_top_asserts #(
  parameter int NFLAG       = 8,
  parameter int RECOV_LONG  = `SBL_RECOV_LONG,
  parameter int RECOV_SHORT = `SBL_RECOV_SHORT
) (
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire logic [15:0]      reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic             cpu_wait_exec,
  input wire logic             cpu_stop_exec,
  input wire logic             module_irq,
  input wire logic             brk_req,
  input wire logic             short_recovery_opt,
  input wire logic             watchdog_disable_opt,
  input wire logic [NFLAG-1:0] flag_clr_req,
  input wire logic [NFLAG-1:0] flag_clr_gnt,
  input wire logic             in_break,
  input wire logic             force_swi_vec,
  input wire logic             imask_clear,
  input wire logic             stack_start,
  input wire logic             cpu_clk_en,
  input wire logic             bus_clock_double_en,
  input wire logic             bus_clock_quad_en,
  input wire logic             recov_cnt_rst
  ,input wire logic            watchdog_en
);
  // ==========================================================================
  // shadow of the clear enable bit, written through the register port
  logic clr_q;
  int   rcnt_q;
  int   lim_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clr_q <= 1'h0;
    end else if (reg_wr && reg_addr == `SBL_ADDR_BRK_CTRL) begin
      clr_q <= reg_wdata[`SBL_BIT_CLR_EN];
    end
  end
  // gated cycles after the hold ends; option taken while still held
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_q <= 0;
      lim_q  <= 0;
    end else if (recov_cnt_rst) begin
      rcnt_q <= 0;
      lim_q  <= short_recovery_opt ? RECOV_SHORT : RECOV_LONG;
    end else if (!bus_clock_quad_en) begin
      rcnt_q <= rcnt_q + 1;
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_gate;
    flag_clr_gnt == $past(flag_clr_req & {NFLAG{!in_break || clr_q}});
  endproperty
  a_gate: assert property (p_gate) else $error("flag grant wrong");
  property p_imask;
    (cpu_wait_exec || cpu_stop_exec) && cpu_clk_en |=> imask_clear;
  endproperty
  a_imask: assert property (p_imask) else $error("no mask clear");
  property p_wait;
    cpu_wait_exec && !cpu_stop_exec && cpu_clk_en && !module_irq && !brk_req
      |=> !cpu_clk_en && bus_clock_quad_en && bus_clock_double_en;
  endproperty
  a_wait: assert property (p_wait) else $error("wait clocks wrong");
  property p_wake;
    module_irq && !$past(module_irq) && !cpu_clk_en && bus_clock_quad_en && !brk_req
      && !in_break |-> ##[1:3] stack_start;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake stacking");
  property p_wbrk;
    $rose(brk_req) && !cpu_clk_en && bus_clock_quad_en |-> ##[1:2] force_swi_vec;
  endproperty
  a_wbrk: assert property (p_wbrk) else $error("break left wait wrong");
  property p_wdog;
    !watchdog_disable_opt && $past(!watchdog_disable_opt) && $past(rst_n) |-> watchdog_en;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog off");
  property p_stop;
    cpu_stop_exec && cpu_clk_en
      |=> !bus_clock_quad_en && !bus_clock_double_en && recov_cnt_rst;
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry wrong");
  property p_hold;
    recov_cnt_rst && !module_irq && !brk_req |=> recov_cnt_rst && !bus_clock_quad_en;
  endproperty
  a_hold: assert property (p_hold) else $error("counter hold lost");
  property p_recov;
    $rose(bus_clock_quad_en) && lim_q != 0 |-> rcnt_q >= lim_q && rcnt_q <= lim_q + 1;
  endproperty
  a_recov: assert property (p_recov) else $error("recovery length wrong");
  property p_stack;
    stack_start |-> cpu_clk_en && bus_clock_quad_en;
  endproperty
  a_stack: assert property (p_stack) else $error("stacking while gated");
  property p_rdata;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule
bind sbl_top sbl_top_asserts #(
  .NFLAG(NFLAG), .RECOV_LONG(RECOV_LONG), .RECOV_SHORT(RECOV_SHORT)
) u_chk (
  .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_wait_exec,
  .cpu_stop_exec, .module_irq, .brk_req, .short_recovery_opt, .watchdog_disable_opt,
  .flag_clr_req, .flag_clr_gnt, .in_break, .force_swi_vec, .imask_clear, .stack_start,
  .cpu_clk_en, .bus_clock_double_en, .bus_clock_quad_en, .recov_cnt_rst, .watchdog_en
);
`default_nettype wire

// File: test/sbl_core_model.sv
// stand-in for the processor core and one interrupting peripheral
`timescale 1ns/1ns
`default_nettype none
module sbl_core_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic go_wait,
  input  wire logic go_stop,
  input  wire logic go_irq,
  input  wire logic stack_start,
  output logic      cpu_wait_exec,
  output logic      cpu_stop_exec,
  output logic      module_irq
);
  // ==========================================================================
  // instruction finishes one cycle after the bench asks for it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_wait_exec <= 1'h0;
      cpu_stop_exec <= 1'h0;
    end else begin
      cpu_wait_exec <= go_wait;
      cpu_stop_exec <= go_stop;
    end
  end
  // request stays pending until serviced, so a late wake is not masked
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      module_irq <= 1'h0;
    end else if (go_irq) begin
      module_irq <= 1'h1;
    end else if (stack_start) begin
      module_irq <= 1'h0;
    end
  end
endmodule
`default_nettype wire

// File: test/sys_break_lowpower_status_tb.sv
// self-checking bench for the break/low-power block
`timescale 1ns/1ns
`default_nettype none
`include "sbl_cfg.svh"
module sys_break_lowpower_status_tb;
  localparam int LONG = 64;
  localparam int SHORT = 4;
  logic clk_sys = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, sro = 1'h0, wdo = 1'h0;
  logic brk_req = 1'h0, brk_done = 1'h0, power_on_evt = 1'h0, ipin = 1'h0;
  logic go_wait = 1'h0, go_stop = 1'h0, go_irq = 1'h0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, clr_req = 8'h00, reg_rdata, clr_gnt, rd_v;
  logic [5:0]  evt = 6'h00;
  logic cpu_wait_exec, cpu_stop_exec, module_irq, in_break, force_swi_vec, imask_clear;
  logic stack_start, cpu_clk_en, bcd, bcq, recov_cnt_rst, watchdog_en, irq;
  int error_cnt = 0, n_checks = 0, n_swi = 0, n_stack = 0, n_imask = 0, b0, b1;
  // ==========================================================================
  // block and partner
  sbl_top #(.RECOV_LONG(LONG), .RECOV_SHORT(SHORT)) u_dut (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_wait_exec,
    .cpu_stop_exec, .module_irq, .brk_req, .brk_done, .power_on_evt,
    .pin_rst_evt(evt[5]), .wdog_rst_evt(evt[4]), .bad_opcode_evt(evt[3]),
    .bad_fetch_evt(evt[2]), .monitor_entry_evt(evt[1]), .low_voltage_evt(evt[0]),
    .irq_pin_high(ipin), .vec_fffe(8'hFF), .vec_ffff(8'hFF), .short_recovery_opt(sro),
    .watchdog_disable_opt(wdo), .flag_clr_req(clr_req), .flag_clr_gnt(clr_gnt), .in_break,
    .force_swi_vec, .imask_clear, .stack_start, .cpu_clk_en, .bus_clock_double_en(bcd),
    .bus_clock_quad_en(bcq), .recov_cnt_rst, .watchdog_en, .irq);
  sbl_core_model u_core (.clk_sys, .rst_n, .go_wait, .go_stop, .go_irq, .stack_start,
    .cpu_wait_exec, .cpu_stop_exec, .module_irq);
  always #4 clk_sys = ~clk_sys;
  // pulse tallies; the edge reads values from before its own updates
  always @(posedge clk_sys) begin
    if (force_swi_vec === 1'h1) n_swi++;
    if (stack_start === 1'h1) n_stack++;
    if (imask_clear === 1'h1) n_imask++;
  end
  // ==========================================================================
  // helpers
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  // read data sit only in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 rd_v = reg_rdata;
    chk(rd_v & m, e);
  endtask
  task automatic wait_in(input logic [1:0] cmd);
    @(posedge clk_sys);
    {go_wait, go_stop} <= cmd;
    @(posedge clk_sys);
    {go_wait, go_stop} <= 2'h0;
    tick();
    tick();
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_rst_src;
    evt <= 6'h02;
    @(posedge clk_sys);
    {evt, ipin} <= 7'h01;
    rdc(`SBL_ADDR_RST_SRC, 8'hFF, `SBL_RST_SRC_INIT);
    rdc(`SBL_ADDR_RST_SRC, 8'hFF, 8'h00);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      evt <= 6'h01 << k;
      @(posedge clk_sys);
      evt <= 6'h00;
      rdc(`SBL_ADDR_RST_SRC, 8'hFF, 8'h02 << k);
      rdc(`SBL_ADDR_RST_SRC, 8'hFF, 8'h00);
    end
    @(posedge clk_sys);
    evt <= 6'h20;
    @(posedge clk_sys);
    evt <= 6'h00;
    power_on_evt <= 1'h1;
    @(posedge clk_sys);
    power_on_evt <= 1'h0;
    rdc(`SBL_ADDR_RST_SRC, 8'hFF, `SBL_RST_SRC_INIT);
    rdc(16'hFE02, 8'hFF, 8'h00);
  endtask
  task automatic t_break;
    wr(`SBL_ADDR_BRK_CTRL, 8'h00);
    clr_req <= 8'hFF;
    tick();
    chk(clr_gnt, 8'hFF);
    b0 = n_swi;
    brk_req <= 1'h1;
    @(posedge clk_sys);
    brk_req <= 1'h0;
    for (int i = 0; i < 16 && in_break !== 1'h1; i++) tick();
    tick();
    chk(8'(n_swi - b0), 8'h01);
    chk(clr_gnt, 8'h00);
    wr(`SBL_ADDR_BRK_CTRL, 8'h80);
    tick();
    chk(clr_gnt, 8'hFF);
    rdc(`SBL_ADDR_BRK_CTRL, 8'h80, 8'h80);
    wr(`SBL_ADDR_BRK_CTRL, 8'h00);
    tick();
    chk(clr_gnt, 8'h00);
    brk_done <= 1'h1;
    @(posedge clk_sys);
    brk_done <= 1'h0;
    for (int i = 0; i < 16 && in_break !== 1'h0; i++) tick();
    tick();
    chk(clr_gnt, 8'hFF);
    clr_req <= 8'h00;
  endtask
  task automatic t_wait(input logic brk);
    b0 = n_imask;
    b1 = n_stack;
    wait_in(2'h2);
    chk({4'h0, cpu_clk_en, bcd, bcq, watchdog_en}, 8'h07);
    chk(8'(n_imask - b0), 8'h01);
    b0 = n_swi;
    brk_req <= brk;
    go_irq <= !brk;
    @(posedge clk_sys);
    {brk_req, go_irq} <= 2'h0;
    for (int i = 0; i < 8 && n_stack == b1 && n_swi == b0; i++) tick();
    chk({6'h0, 1'(n_swi - b0), 1'(n_stack - b1)}, {6'h0, brk, !brk});
    chk({7'h0, cpu_clk_en}, 8'h01);
  endtask
  task automatic t_wait_brk;
    wr(`SBL_ADDR_IRQ_MASK, 8'h01);
    t_wait(1'h1);
    rdc(`SBL_ADDR_BRK_STAT, 8'h02, 8'h02);
    chk({7'h0, irq}, 8'h01);
    wr(`SBL_ADDR_BRK_STAT, 8'h00);
    rdc(`SBL_ADDR_BRK_STAT, 8'h02, 8'h00);
    wr(`SBL_ADDR_IRQ_MASK, 8'h00);
    tick();
    chk({7'h0, irq}, 8'h00);
    wr(`SBL_ADDR_IRQ_MASK, 8'h01);
    wr(`SBL_ADDR_IRQ_STAT, 8'h01);
    tick();
    chk({7'h0, irq}, 8'h00);
    brk_done <= 1'h1;
    @(posedge clk_sys);
    brk_done <= 1'h0;
  endtask
  task automatic t_stop;
    int n;
    for (int s = 0; s < 2; s++) begin
      sro <= (s == 0);
      wait_in(2'h1);
      chk({5'h0, bcd, bcq, recov_cnt_rst}, 8'h01);
      b1 = n_stack;
      go_irq <= 1'h1;
      @(posedge clk_sys);
      go_irq <= 1'h0;
      for (n = 0; n < 200 && n_stack == b1; n++) tick();
      b0 = (s == 0) ? SHORT : LONG;
      chk({7'h0, 1'(n >= b0 && n <= b0 + 4)}, 8'h01);
      chk({6'h0, bcd, bcq}, 8'h03);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_rst_src();
    t_break();
    t_wait(1'h0);
    t_wait_brk();
    t_stop();
    wdo <= 1'h1;
    tick();
    chk({7'h0, watchdog_en}, 8'h00);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
